// ==== hw/serial_pll_defs.svh ====
`ifndef SERIAL_PLL_DEFS_SVH
`define SERIAL_PLL_DEFS_SVH

// shift register and frame layout, last bit shifted sits in bit 0
`define SR_W 23
`define DEST_POS 0
`define REF_LSB 1
`define REF_W 14
`define SWAL_LSB 1
`define SWAL_W 7
`define MAIN_LSB 8
`define MAIN_W 11
`define PRE_SEL_POS 19
`define CUR_SEL_POS 20
`define MON_SEL_POS 21
`define POL_POS 22

// reset values of the latched words
`define REF_RST 14'h0003
`define MAIN_RST 11'h003
`define SWAL_RST 7'h00
`define PRE_SEL_RST 1'b1
`define CUR_SEL_RST 1'b0
`define MON_SEL_RST 1'b0
`define POL_RST 1'b1

// prescaler base moduli
`define PRE_MOD_LOW 8'h40
`define PRE_MOD_HIGH 8'h80

// timing counts, the first two in clk cycles, SOFT_COMPARES in phase compares
`define LOCK_ERR_CYC 4
`define ERR_LIMIT_CYC 8
`define SOFT_COMPARES 4

// synchronised pin indices
`define PIN_DATA 0
`define PIN_SCLK 1
`define PIN_LATCH 2
`define PIN_STBY 3
`define PIN_GATE 4
`define PIN_OSC 5
`define PIN_VCO 6
`define PIN_N 7

`endif

// ==== hw/serial_pll_divider_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "serial_pll_defs.svh"

// Operation
// R1 - main divider is 11-bit, ratio 3..2047, vco = (M*N+A)*osc/R
// R2 - swallow counter is 7-bit, preset 0..127
// R3 - reference divider is 14-bit, ratio 3..16383
// R4 - prescaler base ratio M is 64 or 128
// R5 - one data bit shifts in on each serial clock rising edge
// R6 - rising latch strobe moves shift register into selected latch
// R7 - destination high loads reference word, low loads divider and options
// R8 - host never programs reference or main ratio below 3
// R9 - counter fields are straight binary, highest bit most significant
// R10 - prescaler select high gives 64/65, low gives 128/129
// R11 - pump current select high means high current, low means low
// R12 - monitor select high puts monitor rate on pin, low lock indicator
// R13 - polarity high: pump and phase outputs follow the high table
// R14 - polarity low: pump and phase outputs reversed except when equal
// R15 - monitor shows reference rate with polarity high, divided rate low
// R16 - pump gate low forces pump output to high impedance
// R17 - standby low enters power saving, high resumes normal operation
// R18 - in power saving the pump output is high impedance
// R19 - in power saving the lock indicator stays high
// R20 - after power saving the phase error magnitude is limited
// R21 - host holds standby low at least 1 us after power-on
// R22 - host keeps latch strobe low while shifting bits
// R23 - destination bit is the last bit shifted before the strobe
module serial_pll_divider_control #(
	parameter int LOCK_ERR_CYCLES = `LOCK_ERR_CYC,
	parameter int ERR_LIMIT_CYCLES = `ERR_LIMIT_CYC,
	parameter int SOFT_COMPARES = `SOFT_COMPARES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic serial_data,
	input wire logic serial_clk,
	input wire logic latch_strobe,
	input wire logic standby_control,
	input wire logic pump_output_gate,
	input wire logic osc_in,
	input wire logic vco_in,
	output logic pump_out,
	output logic pump_oe,
	output logic ref_phase_out,
	output logic comp_phase_out,
	output logic comp_phase_oe,
	output logic lock_monitor_out,
	output logic [`REF_W-1:0] ref_ratio,
	output logic [`MAIN_W-1:0] main_ratio,
	output logic [`SWAL_W-1:0] swallow_count,
	output logic prescaler_ratio_select,
	output logic pump_current_high,
	output logic standby_active
);
	// refuse counts the error counter cannot hold
	if (LOCK_ERR_CYCLES < 1 || LOCK_ERR_CYCLES > 255 || ERR_LIMIT_CYCLES < 1
			|| ERR_LIMIT_CYCLES > 255 || SOFT_COMPARES < 1 || SOFT_COMPARES > 255) begin : g_chk
		$error("serial_pll_divider_control: bad count parameter");
	end

	// pin synchronisers, two flops per pin, third flop for edge finding
	wire logic [`PIN_N-1:0] pins = {vco_in, osc_in, pump_output_gate, standby_control,
		latch_strobe, serial_clk, serial_data};
	logic [`PIN_N-1:0] s1_q;
	logic [`PIN_N-1:0] s2_q;
	logic [`PIN_N-1:0] s3_q;
	for (genvar i = 0; i < `PIN_N; i++) begin : g_sync
		always_ff @(posedge clk) begin
			if (rst) begin
				s1_q[i] <= 1'b0;
				s2_q[i] <= 1'b0;
				s3_q[i] <= 1'b0;
			end else begin
				s1_q[i] <= pins[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
			end
		end
	end
	function automatic logic rose(input logic [`PIN_N-1:0] now, input logic [`PIN_N-1:0] old,
			input int idx);
		rose = now[idx] & ~old[idx];
	endfunction : rose
	wire logic sclk_rise = rose(s2_q, s3_q, `PIN_SCLK);
	wire logic latch_rise = rose(s2_q, s3_q, `PIN_LATCH);
	wire logic osc_rise = rose(s2_q, s3_q, `PIN_OSC);
	wire logic vco_rise = rose(s2_q, s3_q, `PIN_VCO);
	wire logic standby = ~s2_q[`PIN_STBY]; // R17
	wire logic wake = s2_q[`PIN_STBY] & ~s3_q[`PIN_STBY];
	// serial shift register and latched words
	logic [`SR_W-1:0] sr_q, sr_d;
	logic [`REF_W-1:0] ref_q, ref_d;
	logic [`MAIN_W-1:0] main_q, main_d;
	logic [`SWAL_W-1:0] swal_q, swal_d;
	logic pre_sel_q, pre_sel_d, cur_sel_q, cur_sel_d;
	logic mon_sel_q, mon_sel_d, pol_q, pol_d;
	// shift and latch; strobe high during shifting is the host's concern
	always_comb begin
		sr_d = sr_q;
		ref_d = ref_q;
		main_d = main_q;
		swal_d = swal_q;
		pre_sel_d = pre_sel_q;
		cur_sel_d = cur_sel_q;
		mon_sel_d = mon_sel_q;
		pol_d = pol_q;
		if (sclk_rise) begin
			sr_d = {sr_q[`SR_W-2:0], s2_q[`PIN_DATA]}; // R5 R22 R23
		end
		if (latch_rise) begin // R6
			if (sr_q[`DEST_POS]) begin // R7 R23
				ref_d = sr_q[`REF_LSB +: `REF_W]; // R3 R9
			end else begin
				swal_d = sr_q[`SWAL_LSB +: `SWAL_W]; // R2 R9
				main_d = sr_q[`MAIN_LSB +: `MAIN_W]; // R1 R9
				pre_sel_d = sr_q[`PRE_SEL_POS];
				cur_sel_d = sr_q[`CUR_SEL_POS]; // R11
				mon_sel_d = sr_q[`MON_SEL_POS];
				pol_d = sr_q[`POL_POS];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sr_q <= '0;
			ref_q <= `REF_RST;
			main_q <= `MAIN_RST;
			swal_q <= `SWAL_RST;
			pre_sel_q <= `PRE_SEL_RST;
			cur_sel_q <= `CUR_SEL_RST;
			mon_sel_q <= `MON_SEL_RST;
			pol_q <= `POL_RST;
		end else begin
			sr_q <= sr_d;
			ref_q <= ref_d;
			main_q <= main_d;
			swal_q <= swal_d;
			pre_sel_q <= pre_sel_d;
			cur_sel_q <= cur_sel_d;
			mon_sel_q <= mon_sel_d;
			pol_q <= pol_d;
		end
	end

	// reference and pulse-swallow dividers, held in standby
	logic [`REF_W-1:0] rcnt_q, rcnt_d;
	logic [7:0] pcnt_q, pcnt_d;
	logic [`MAIN_W-1:0] ncnt_q, ncnt_d;
	logic [`SWAL_W-1:0] acnt_q, acnt_d;
	logic fr_q, fr_d, fp_q, fp_d;
	logic [7:0] modulus;
	always_comb begin
		modulus = pre_sel_q ? `PRE_MOD_LOW : `PRE_MOD_HIGH; // R4 R10
		rcnt_d = rcnt_q;
		pcnt_d = pcnt_q;
		ncnt_d = ncnt_q;
		acnt_d = acnt_q;
		fr_d = 1'b0;
		fp_d = 1'b0;
		if (standby) begin // R20
			rcnt_d = ref_q;
			ncnt_d = main_q;
			acnt_d = swal_q;
			pcnt_d = swal_q != '0 ? modulus : modulus - 8'h01;
		end else begin
			if (osc_rise) begin
				if (rcnt_q <= `REF_W'(1)) begin // R3 R8
					rcnt_d = ref_q;
					fr_d = 1'b1;
				end else begin
					rcnt_d = rcnt_q - `REF_W'(1);
				end
			end
			// prescaler divides by M+1 while swallowing, else M
			if (vco_rise) begin
				if (pcnt_q == 8'h00) begin // R1 R2
					if (ncnt_q <= `MAIN_W'(1)) begin
						ncnt_d = main_q;
						acnt_d = swal_q;
						fp_d = 1'b1;
					end else begin
						ncnt_d = ncnt_q - `MAIN_W'(1);
						acnt_d = acnt_q != '0 ? acnt_q - `SWAL_W'(1) : acnt_q;
					end
					pcnt_d = acnt_d != '0 ? modulus : modulus - 8'h01;
				end else begin
					pcnt_d = pcnt_q - 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rcnt_q <= `REF_RST;
			pcnt_q <= 8'h00;
			ncnt_q <= `MAIN_RST;
			acnt_q <= `SWAL_RST;
			fr_q <= 1'b0;
			fp_q <= 1'b0;
		end else begin
			rcnt_q <= rcnt_d;
			pcnt_q <= pcnt_d;
			ncnt_q <= ncnt_d;
			acnt_q <= acnt_d;
			fr_q <= fr_d;
			fp_q <= fp_d;
		end
	end

	// phase frequency detector with error width, lock and soft start
	serial_pll_pkg::pfd_state_t st_q, st_d;
	logic [7:0] err_q, err_d;
	logic [7:0] soft_q, soft_d;
	logic lock_q, lock_d;
	always_comb begin
		st_d = st_q;
		err_d = err_q;
		soft_d = soft_q;
		lock_d = lock_q;
		case (st_q)
			serial_pll_pkg::PFD_IDLE: begin
				if (fr_q && !fp_q) begin
					st_d = serial_pll_pkg::PFD_UP;
				end else if (fp_q && !fr_q) begin
					st_d = serial_pll_pkg::PFD_DOWN;
				end
			end
			serial_pll_pkg::PFD_UP: begin
				if (fp_q) begin
					st_d = serial_pll_pkg::PFD_IDLE;
				end
			end
			serial_pll_pkg::PFD_DOWN: begin
				if (fr_q) begin
					st_d = serial_pll_pkg::PFD_IDLE;
				end
			end
			default: st_d = serial_pll_pkg::PFD_IDLE;
		endcase
		if (st_d == serial_pll_pkg::PFD_IDLE) begin
			err_d = 8'h00;
		end else if (err_q != 8'hff) begin
			err_d = err_q + 8'h01;
		end
		if (st_q != serial_pll_pkg::PFD_IDLE && st_d == serial_pll_pkg::PFD_IDLE) begin
			lock_d = err_q < 8'(LOCK_ERR_CYCLES);
			soft_d = soft_q != 8'h00 ? soft_q - 8'h01 : soft_q;
		end
		if (standby) begin
			st_d = serial_pll_pkg::PFD_IDLE;
			err_d = 8'h00;
			lock_d = 1'b1; // R19
		end
		if (wake) begin
			soft_d = 8'(SOFT_COMPARES); // R20
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= serial_pll_pkg::PFD_IDLE;
			err_q <= 8'h00;
			soft_q <= 8'h00;
			lock_q <= 1'b1;
		end else begin
			st_q <= st_d;
			err_q <= err_d;
			soft_q <= soft_d;
			lock_q <= lock_d;
		end
	end

	// output pin registers
	logic pump_out_q, pump_out_d, pump_oe_q, pump_oe_d;
	logic rphase_q, rphase_d, cphase_oe_q, cphase_oe_d, mon_q, mon_d, stby_q, stby_d;
	logic fast, slow, limited;
	always_comb begin
		// reference ahead means up state; polarity low swaps the roles
		fast = st_q == (pol_q ? serial_pll_pkg::PFD_UP : serial_pll_pkg::PFD_DOWN);
		slow = st_q == (pol_q ? serial_pll_pkg::PFD_DOWN : serial_pll_pkg::PFD_UP);
		limited = soft_q != 8'h00 && err_q >= 8'(ERR_LIMIT_CYCLES); // R20
		pump_out_d = fast;
		rphase_d = slow;
		cphase_oe_d = fast;
		if (st_q == serial_pll_pkg::PFD_IDLE) begin
			pump_out_d = 1'b0;
			rphase_d = 1'b0;
			cphase_oe_d = 1'b0;
		end
		pump_oe_d = st_q != serial_pll_pkg::PFD_IDLE; // R13 R14
		if (!s2_q[`PIN_GATE] || standby || limited) begin
			pump_oe_d = 1'b0; // R16 R18
		end
		if (mon_sel_q) begin // R12
			mon_d = pol_q ? fr_q : fp_q; // R15
		end else begin
			mon_d = lock_q;
		end
		stby_d = standby; // R17
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			pump_out_q <= 1'b0;
			pump_oe_q <= 1'b0;
			rphase_q <= 1'b0;
			cphase_oe_q <= 1'b0;
			mon_q <= 1'b1;
			stby_q <= 1'b1;
		end else begin
			pump_out_q <= pump_out_d;
			pump_oe_q <= pump_oe_d;
			rphase_q <= rphase_d;
			cphase_oe_q <= cphase_oe_d;
			mon_q <= mon_d;
			stby_q <= stby_d;
		end
	end

	// every output straight from a flop, except comp_phase_out which is tied low
	assign pump_out = pump_out_q;
	assign pump_oe = pump_oe_q;
	assign ref_phase_out = rphase_q;
	assign comp_phase_out = 1'b0; // open drain only ever pulls low
	assign comp_phase_oe = cphase_oe_q;
	assign lock_monitor_out = mon_q;
	assign ref_ratio = ref_q;
	assign main_ratio = main_q;
	assign swallow_count = swal_q;
	assign prescaler_ratio_select = pre_sel_q;
	assign pump_current_high = cur_sel_q;
	assign standby_active = stby_q;
endmodule : serial_pll_divider_control
`default_nettype wire

// ==== hw/serial_pll_pkg.sv ====
`default_nettype none
package serial_pll_pkg;
	// phase detector error state
	typedef enum logic [1:0] {
		PFD_IDLE,
		PFD_UP,
		PFD_DOWN
	} pfd_state_t;
endpackage : serial_pll_pkg
`default_nettype wire

// ==== tb/serial_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_host (
	output var logic serial_data,
	output var logic serial_clk,
	output var logic latch_strobe
);
	// link idles with clock and strobe low
	initial begin
		serial_data = 1'b0;
		serial_clk = 1'b0;
		latch_strobe = 1'b0;
	end
	// n bits msb first, destination bit last, then a strobe pulse
	task automatic send(input logic [22:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			serial_data = w[i];
			#80 serial_clk = 1'b1;
			#80 serial_clk = 1'b0;
		end
		serial_data = ~serial_data; // stale data no longer valid
		#80 latch_strobe = 1'b1;
		#120 latch_strobe = 1'b0;
		#80;
	endtask : send
endmodule : serial_host
`default_nettype wire

// ==== tb/serial_pll_divider_control_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "serial_pll_defs.svh"
module serial_pll_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic latch_strobe,
	input wire logic standby_control,
	input wire logic pump_output_gate,
	input wire logic pump_out,
	input wire logic pump_oe,
	input wire logic ref_phase_out,
	input wire logic comp_phase_oe,
	input wire logic lock_monitor_out,
	input wire logic [`REF_W-1:0] ref_ratio,
	input wire logic [`MAIN_W-1:0] main_ratio,
	input wire logic [`SWAL_W-1:0] swallow_count,
	input wire logic prescaler_ratio_select,
	input wire logic pump_current_high,
	input wire logic standby_active
);
	logic [3:0] up_q;
	logic [3:0] up_d;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// cycles since reset, saturating
	always_comb begin
		up_d = (up_q == 4'hf) ? up_q : up_q + 4'h1;
	end
	always_ff @(posedge clk) begin
		up_q <= rst ? 4'h0 : up_d;
	end
	sequence gate_low_s; !pump_output_gate [*4]; endsequence
	sequence stby_low_s; !standby_control [*4]; endsequence
	sequence stby_high_s; standby_control [*4] ##0 (up_q > 4'h5); endsequence
	gate_off_a: assert property (gate_low_s |-> !pump_oe)
		else $error("pump drives with gate low");
	standby_z_a: assert property (standby_active [*2] |-> !pump_oe)
		else $error("pump drives in standby");
	standby_in_a: assert property (stby_low_s |-> standby_active)
		else $error("standby not entered");
	standby_out_a: assert property (stby_high_s |-> !standby_active)
		else $error("standby not left");
	latch_hold_a: assert property (!latch_strobe [*6] |=> $stable({ref_ratio, main_ratio,
		swallow_count, prescaler_ratio_select, pump_current_high}))
		else $error("latched word changed without strobe");
	drive_high_a: assert property (pump_oe && pump_out |-> !ref_phase_out && comp_phase_oe)
		else $error("phase outputs disagree with pump high");
	drive_low_a: assert property (pump_oe && !pump_out |-> ref_phase_out && !comp_phase_oe)
		else $error("phase outputs disagree with pump low");
	reset_vals_a: assert property ($fell(rst) |-> ref_ratio == 14'h0003 && lock_monitor_out
		&& main_ratio == 11'h003 && swallow_count == 7'h00 && !pump_oe)
		else $error("bad values after reset");
endmodule : serial_pll_checker
bind serial_pll_divider_control serial_pll_checker chk (.clk, .rst, .latch_strobe,
	.standby_control, .pump_output_gate, .pump_out, .pump_oe, .ref_phase_out, .comp_phase_oe,
	.lock_monitor_out, .ref_ratio, .main_ratio, .swallow_count, .prescaler_ratio_select,
	.pump_current_high, .standby_active);
`default_nettype wire

// ==== tb/serial_pll_divider_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "serial_pll_defs.svh"
module serial_pll_divider_control_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic standby_control = 1'b0;
	logic pump_output_gate = 1'b1;
	logic osc_in = 1'b0;
	logic vco_in = 1'b0;
	wire logic serial_data, serial_clk, latch_strobe;
	wire logic pump_out, pump_oe, ref_phase_out, comp_phase_out, comp_phase_oe, lock_monitor_out;
	wire logic [`REF_W-1:0] ref_ratio;
	wire logic [`MAIN_W-1:0] main_ratio;
	wire logic [`SWAL_W-1:0] swallow_count;
	wire logic prescaler_ratio_select, pump_current_high, standby_active;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	// clock and free-running reference and vco pins
	always #10 clk = ~clk;
	always #50 osc_in = ~osc_in;
	always #40 vco_in = ~vco_in;
	serial_host host (.serial_data, .serial_clk, .latch_strobe);
	serial_pll_divider_control uut (.clk, .rst, .serial_data, .serial_clk, .latch_strobe,
		.standby_control, .pump_output_gate, .osc_in, .vco_in, .pump_out, .pump_oe,
		.ref_phase_out, .comp_phase_out, .comp_phase_oe, .lock_monitor_out, .ref_ratio,
		.main_ratio, .swallow_count, .prescaler_ratio_select, .pump_current_high,
		.standby_active);
	task automatic end_sim();
		if (fail_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : settle
	function automatic logic [22:0] div_w(input logic pol, mon, cur, pre,
		input logic [10:0] n, input logic [6:0] a);
		return {pol, mon, cur, pre, n, a, 1'b0};
	endfunction : div_w
	task automatic t_reset();
		chk("ref_ratio", 16'h0003, {2'h0, ref_ratio});
		chk("main_ratio", 16'h0003, {5'h0, main_ratio});
		chk("swallow", 16'h0000, {9'h0, swallow_count});
		chk("opts", 16'h0001, {14'h0, pump_current_high, prescaler_ratio_select});
		chk("standby", 16'h0005, {13'h0, standby_active, pump_oe, lock_monitor_out});
	endtask : t_reset
	task automatic t_ref();
		logic [13:0] r[2] = '{14'h3fff, 14'h0003};
		foreach (r[i]) begin
			host.send({8'h00, r[i], 1'b1}, 15);
			settle(4);
			chk("ref_ratio", {2'h0, r[i]}, {2'h0, ref_ratio});
			chk("main_kept", 16'h0003, {5'h0, main_ratio});
		end
	endtask : t_ref
	task automatic t_div(input logic cur, pre, input logic [10:0] n, input logic [6:0] a);
		host.send(div_w(1'b1, 1'b0, cur, pre, n, a), 23);
		settle(4);
		chk("main_ratio", {5'h0, n}, {5'h0, main_ratio});
		chk("swallow", {9'h0, a}, {9'h0, swallow_count});
		chk("opts", {14'h0, cur, pre}, {14'h0, pump_current_high, prescaler_ratio_select});
		chk("ref_kept", 16'h0003, {2'h0, ref_ratio});
	endtask : t_div
	task automatic t_phase(input logic pol, input logic [2:0] exp);
		host.send(div_w(pol, 1'b0, 1'b0, 1'b1, 11'h003, 7'h00), 23);
		settle(6);
		for (int i = 0; i < 8000 && pump_oe !== 1'b1; i++) settle(1);
		settle(2);
		chk("pump_oe", 16'h0001, {15'h0, pump_oe});
		chk("phase_outs", {13'h0, exp}, {13'h0, pump_out, ref_phase_out, comp_phase_oe});
		chk("comp_phase", 16'h0000, {15'h0, comp_phase_out});
	endtask : t_phase
	task automatic t_mon(input logic pol, input logic hi);
		int n = 0;
		logic prev;
		host.send(div_w(pol, 1'b1, 1'b0, 1'b1, 11'h003, 7'h00), 23);
		settle(6);
		prev = lock_monitor_out;
		repeat (200) begin
			settle(1);
			if (lock_monitor_out === 1'b1 && prev === 1'b0) n++;
			prev = lock_monitor_out;
		end
		chk("monitor_rate", {15'h0, hi}, {15'h0, n >= 10});
	endtask : t_mon
	task automatic t_stby();
		int on = 0;
		host.send(div_w(1'b1, 1'b0, 1'b0, 1'b1, 11'h003, 7'h00), 23);
		standby_control = 1'b0;
		settle(5);
		chk("standby", 16'h0005, {13'h0, standby_active, pump_oe, lock_monitor_out});
		pump_output_gate = 1'b0;
		standby_control = 1'b1;
		// first compare after wake runs long, so the pump would drive early in it
		repeat (100) begin
			settle(1);
			if (pump_oe !== 1'b0) on++;
		end
		chk("gate_off", 16'h0000, on[15:0]);
		chk("standby_left", 16'h0000, {15'h0, standby_active});
		// error already past its limit inside the soft start window
		pump_output_gate = 1'b1;
		settle(8);
		chk("soft_limit", 16'h0000, {15'h0, pump_oe});
	endtask : t_stby
	initial begin
		settle(12);
		rst = 1'b0;
		t_reset();
		t_ref();
		t_div(1'b1, 1'b0, 11'h7ff, 7'h7f);
		t_div(1'b0, 1'b1, 11'h003, 7'h00);
		standby_control = 1'b1;
		t_phase(1'b1, 3'b101);
		t_phase(1'b0, 3'b010);
		t_mon(1'b1, 1'b1);
		t_mon(1'b0, 1'b0);
		t_stby();
		end_sim();
	end
endmodule : serial_pll_divider_control_tb_top
`default_nettype wire
